//--- hw/cotbk_pkg.sv
// package: constants, states and signal groups for the buck channel control block
package cotbk_pkg;
  // clock rate in MHz
  localparam int CLK_MHZ = 250;
  // minimum off-time in ns, rounded up to cycles
  localparam int MIN_OFF_NS = 400;
  localparam int MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;
  // negative over-current wait in ns, least time rounded up
  localparam int NEG_WAIT_NS = 2500;
  localparam int NEG_WAIT_CYC = (NEG_WAIT_NS * CLK_MHZ + 999) / 1000;
  // negative over-current re-sense pulse in ns
  localparam int NEG_PULSE_NS = 300;
  localparam int NEG_PULSE_CYC = (NEG_PULSE_NS * CLK_MHZ + 999) / 1000;
  // power-good and undervoltage deglitch in ns
  localparam int DEGLITCH_NS = 5000;
  localparam int DEGLITCH_CYC = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  // zero crossings needed to enter pulse-skip mode
  localparam int SKIP_ENTRY_CNT = 8;
  // soft-start phase length and phase count in switching cycles
  localparam int SS_PHASE_CYC = 110;
  localparam int SS_PHASES = 4;
  localparam int SS_TOTAL_CYC = SS_PHASE_CYC * SS_PHASES;
  // counter width for all timers
  localparam int TMR_W = 12;
  // soft-start limit fraction codes (quarters of full limit)
  localparam logic [1:0] LIM_25 = 2'h0;
  localparam logic [1:0] LIM_100 = 2'h3;

  // decoded enable pin state
  typedef enum logic [1:0] {
    COTBK_EN_OFF,
    COTBK_EN_CCM,
    COTBK_EN_SKIP
  } cotbk_en_e;

  // switching phase state
  typedef enum logic [2:0] {
    COTBK_IDLE,
    COTBK_HIGH_ON,
    COTBK_LOW_ON,
    COTBK_NEG_WAIT,
    COTBK_NEG_PULSE,
    COTBK_LATCHED
  } cotbk_state_e;

  // comparator inputs from the analog front end
  typedef struct packed {
    logic on_time_done;   // on-time capacitor reached output level
    logic half_on_done;   // extra half on-time elapsed (stretch one-shot)
    logic fb_low;         // feedback at or below regulation
    logic zero_cross;     // phase node crossed power ground
    logic pos_ocp;        // low-side current above limit
    logic neg_ocp;        // phase node above negative threshold
    logic out_in_window;  // output within +/-10 percent
    logic out_above_90;   // output above 90 percent
    logic out_under_70;   // output 30 percent low
    logic out_over_110;   // output 10 percent high
  } cotbk_cmp_s;

  // gate and analog control outputs
  typedef struct packed {
    logic high_side_gate_en;
    logic low_side_gate_en;
    logic gates_hiz;
    logic limit_src_en;
    logic on_time_start;
    logic on_time_stretch;
  } cotbk_drv_s;
endpackage : cotbk_pkg

//--- hw/cotbk_channel.sv
// module: control logic for one constant on-time buck channel
// Functional notes
// - on-time ends from capacitor comparator, no clock
// - pin at supply: enable plus pulse-skip
// - pin floating: enable, continuous conduction only
// - pin low: shut down, both gates high-Z
// - enter skip after eight consecutive zero crossings
// - in skip, low gate off at zero
// - in skip, stretch on-time by half
// - missing crossing exits skip, restarts count
// - limit source on only with low side
// - positive over-current blocks next high turn-on
// - negative current threshold turns low side off
// - wait, pulse low gate, repeat until clear
// - power-good low outside ten percent window
// - power-good held low through soft-start, 90 percent
// - power-good follows window after 5 us persistence, drops at once on disable or fault
// - extreme over-current keeps high off, UV latch
// - power-good only pulled low, external pull-up
// - minimum 400 ns off-time between on-times
// - four soft-start phases, first doubles off-time
// - 30 percent undervoltage for 5 us after soft-start latches off
`timescale 1ns/1ns
module cotbk_channel
  import cotbk_pkg::*;
#(
  parameter int DEGLITCH_CYCLES = DEGLITCH_CYC  // deglitch length, shortenable
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // enable pin sensing: driven high, driven low (floating = neither)
  input wire logic EN_PIN_HIGH_I,
  input wire logic EN_PIN_LOW_I,
  // analog supply good
  input wire logic SUPPLY_OK_I,
  // comparator inputs
  input wire cotbk_cmp_s CMP_I,
  // gate and analog controls
  output cotbk_drv_s DRV_O,
  output logic [1:0] LIMIT_LEVEL_O,
  // open-drain power-good
  output logic POWER_GOOD_OUT_O,
  output logic POWER_GOOD_OUT_OE_O,
  // status
  output logic SKIP_MODE_O,
  output logic FAULT_LATCHED_O
);
  // refuse a filter length that the timers cannot count
  if (DEGLITCH_CYCLES < 1 || DEGLITCH_CYCLES >= (1 << TMR_W)) begin : g_bad_deglitch
    $error("DEGLITCH_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  cotbk_cmp_s cmp_meta_reg;  // first stage, only read by second
  cotbk_cmp_s cmp_reg;       // synchronised comparators
  logic [2:0] pin_meta_reg;  // first stage for pins
  logic [2:0] pin_reg;       // synchronised pins

  // two flip-flops on every outside input
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      cmp_meta_reg <= '0;
      cmp_reg <= '0;
      pin_meta_reg <= 3'h0;
      pin_reg <= 3'h0;
    end else begin
      cmp_meta_reg <= CMP_I;
      cmp_reg <= cmp_meta_reg;
      pin_meta_reg <= {SUPPLY_OK_I, EN_PIN_LOW_I, EN_PIN_HIGH_I};
      pin_reg <= pin_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable decode
  cotbk_en_e en_mode;     // decoded pin mode
  logic chan_on;          // channel allowed to run
  logic chan_on_prev_reg; // for restart detection

  // decode pin level into off, continuous or skip
  always_comb begin
    if (!pin_reg[2] || pin_reg[1]) begin
      en_mode = COTBK_EN_OFF;
    end else if (pin_reg[0]) begin
      en_mode = COTBK_EN_SKIP;
    end else begin
      en_mode = COTBK_EN_CCM;
    end
  end
  assign chan_on = (en_mode != COTBK_EN_OFF);

  // track enable for start-up detection
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      chan_on_prev_reg <= 1'b0;
    end else begin
      chan_on_prev_reg <= chan_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // switching state machine
  cotbk_state_e state_reg;
  logic [TMR_W-1:0] tmr_reg;     // off-time and negative-current timers
  logic cycle_end;               // one switching cycle completed (new high turn-on)
  logic crossed_reg;             // zero crossing seen this cycle
  logic [3:0] zc_cnt_reg;        // consecutive crossings
  logic skip_reg;                // pulse-skip mode
  logic uv_latch_reg;            // undervoltage latch
  logic ov_latch_reg;            // overvoltage latch
  logic [1:0] ss_phase_reg;      // soft-start phase
  logic [8:0] ss_cnt_reg;        // cycles in phase
  logic ss_done_reg;             // soft-start finished
  logic [TMR_W-1:0] min_off;     // current minimum off-time
  logic start_ok;                // conditions to start an on-time
  logic fault;

  assign fault = uv_latch_reg | ov_latch_reg;
  // first soft-start phase doubles the minimum off-time
  assign min_off = (!ss_done_reg && ss_phase_reg == LIM_25) ?
                   TMR_W'(2 * MIN_OFF_CYC) : TMR_W'(MIN_OFF_CYC);
  // turn on only at regulation, after off-time, no over-current
  assign start_ok = cmp_reg.fb_low && (tmr_reg >= min_off) && !cmp_reg.pos_ocp;
  assign cycle_end = (state_reg == COTBK_LOW_ON || state_reg == COTBK_IDLE) &&
                     start_ok && chan_on && !fault;

  // phase sequencing, one-shot termination and negative current retry
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_reg <= COTBK_IDLE;
      tmr_reg <= '0;
    end else if (!chan_on || (chan_on && !chan_on_prev_reg)) begin
      state_reg <= COTBK_IDLE;
      tmr_reg <= '0;
    end else if (fault) begin
      state_reg <= COTBK_LATCHED;
    end else begin
      case (state_reg)
        COTBK_IDLE: begin
          // switching starts with the low side
          state_reg <= COTBK_LOW_ON;
          tmr_reg <= '0;
        end
        COTBK_HIGH_ON: begin
          // end on capacitor compare, stretched by half in skip
          if (cmp_reg.on_time_done && (!skip_reg || cmp_reg.half_on_done)) begin
            state_reg <= COTBK_LOW_ON;
            tmr_reg <= '0;
          end
        end
        COTBK_LOW_ON: begin
          if (tmr_reg != {TMR_W{1'b1}}) begin
            tmr_reg <= tmr_reg + 1'b1;
          end
          if (cmp_reg.neg_ocp) begin
            state_reg <= COTBK_NEG_WAIT;
            tmr_reg <= '0;
          end else if (start_ok) begin
            state_reg <= COTBK_HIGH_ON;   // high held off under OCP
          end
        end
        COTBK_NEG_WAIT: begin
          tmr_reg <= tmr_reg + 1'b1;
          if (tmr_reg >= TMR_W'(NEG_WAIT_CYC - 1)) begin
            state_reg <= COTBK_NEG_PULSE;
            tmr_reg <= '0;
          end
        end
        COTBK_NEG_PULSE: begin
          tmr_reg <= tmr_reg + 1'b1;
          if (tmr_reg >= TMR_W'(NEG_PULSE_CYC - 1)) begin
            // repeat while still negative, else resume
            state_reg <= cmp_reg.neg_ocp ? COTBK_NEG_WAIT : COTBK_LOW_ON;
            tmr_reg <= cmp_reg.neg_ocp ? '0 : TMR_W'(2 * MIN_OFF_CYC);
          end
        end
        COTBK_LATCHED: state_reg <= COTBK_LATCHED;
        default: state_reg <= COTBK_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pulse-skip entry and exit
  // count zero crossings per switching cycle
  // skip is dropped at once when the pin leaves the skip level
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || en_mode != COTBK_EN_SKIP) begin
      crossed_reg <= 1'b0;
      zc_cnt_reg <= 4'h0;
      skip_reg <= 1'b0;
    end else if (cycle_end) begin
      crossed_reg <= 1'b0;
      if (crossed_reg && en_mode == COTBK_EN_SKIP) begin
        if (zc_cnt_reg < 4'(SKIP_ENTRY_CNT)) begin
          zc_cnt_reg <= zc_cnt_reg + 4'h1;
        end
        if (zc_cnt_reg >= 4'(SKIP_ENTRY_CNT - 1)) begin
          skip_reg <= 1'b1;
        end
      end else begin
        zc_cnt_reg <= 4'h0;
        skip_reg <= 1'b0;
      end
    end else if (state_reg == COTBK_LOW_ON && cmp_reg.zero_cross) begin
      crossed_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // soft-start sequencing
  // four phases of switching cycles
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !chan_on || !chan_on_prev_reg) begin
      ss_phase_reg <= LIM_25;
      ss_cnt_reg <= 9'h000;
      ss_done_reg <= 1'b0;
    end else if (cycle_end && !ss_done_reg) begin
      if (ss_cnt_reg == 9'(SS_PHASE_CYC - 1)) begin
        ss_cnt_reg <= 9'h000;
        if (ss_phase_reg == LIM_100) begin
          ss_done_reg <= 1'b1;
        end else begin
          ss_phase_reg <= ss_phase_reg + 2'h1;
        end
      end else begin
        ss_cnt_reg <= ss_cnt_reg + 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // deglitched output monitors and latches
  logic pg_raw;                  // window condition wanted by power-good
  logic pg_reg;                  // filtered power-good
  logic [TMR_W-1:0] pg_tmr_reg;
  logic [TMR_W-1:0] uv_tmr_reg;
  logic [TMR_W-1:0] ov_tmr_reg;

  assign pg_raw = cmp_reg.out_in_window && cmp_reg.out_above_90;

  // power-good persistence filter, held low until soft-start done
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !chan_on || !ss_done_reg || fault) begin
      pg_reg <= 1'b0;
      pg_tmr_reg <= '0;
    end else if (pg_raw == pg_reg) begin
      pg_tmr_reg <= '0;
    end else if (pg_tmr_reg >= TMR_W'(DEGLITCH_CYCLES - 1)) begin
      pg_reg <= pg_raw;
      pg_tmr_reg <= '0;
    end else begin
      pg_tmr_reg <= pg_tmr_reg + 1'b1;
    end
  end

  // undervoltage and overvoltage fault latches
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !chan_on) begin
      uv_latch_reg <= 1'b0;
      ov_latch_reg <= 1'b0;
      uv_tmr_reg <= '0;
      ov_tmr_reg <= '0;
    end else begin
      if (!ss_done_reg || !cmp_reg.out_under_70) begin
        uv_tmr_reg <= '0;
      end else if (uv_tmr_reg >= TMR_W'(DEGLITCH_CYCLES - 1)) begin
        uv_latch_reg <= 1'b1;
      end else begin
        uv_tmr_reg <= uv_tmr_reg + 1'b1;
      end
      if (!cmp_reg.out_over_110) begin
        ov_tmr_reg <= '0;
      end else if (ov_tmr_reg >= TMR_W'(DEGLITCH_CYCLES - 1)) begin
        ov_latch_reg <= 1'b1;
      end else begin
        ov_tmr_reg <= ov_tmr_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  cotbk_drv_s drv_next;

  // gate control from state
  always_comb begin
    drv_next = '0;
    drv_next.gates_hiz = !chan_on || uv_latch_reg;
    drv_next.high_side_gate_en = chan_on && !fault && (state_reg == COTBK_HIGH_ON);
    drv_next.low_side_gate_en = chan_on && !uv_latch_reg &&
      ((state_reg == COTBK_LOW_ON && !(skip_reg && crossed_reg)) ||
       state_reg == COTBK_NEG_PULSE || ov_latch_reg);
    drv_next.limit_src_en = drv_next.low_side_gate_en;
    drv_next.on_time_start = drv_next.high_side_gate_en;
    drv_next.on_time_stretch = skip_reg;
  end

  // output flops
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      DRV_O <= '{gates_hiz: 1'b1, default: 1'b0};  // gates released in reset
      LIMIT_LEVEL_O <= LIM_25;
      POWER_GOOD_OUT_O <= 1'b0;
      POWER_GOOD_OUT_OE_O <= 1'b1;
      SKIP_MODE_O <= 1'b0;
      FAULT_LATCHED_O <= 1'b0;
    end else begin
      DRV_O <= drv_next;
      LIMIT_LEVEL_O <= ss_done_reg ? LIM_100 : ss_phase_reg;
      POWER_GOOD_OUT_O <= 1'b0;            // only ever drives low
      POWER_GOOD_OUT_OE_O <= !pg_reg;
      SKIP_MODE_O <= skip_reg;
      FAULT_LATCHED_O <= fault;
    end
  end
endmodule : cotbk_channel

//--- tb/cotbk_plant.sv
// plant: half-bridge, inductor and on-time capacitor
`timescale 1ns/1ns
module cotbk_plant
  import cotbk_pkg::*;
#(
  parameter int TON = 8  // on-time in cycles
) (
  // clock, gates and crossing enable
  input wire logic clk_i,
  input wire cotbk_drv_s drv_i,
  input wire logic zc_en_i,
  // comparator levels
  output logic on_done_o,
  output logic half_done_o,
  output logic zc_o
);
  int hi_n = 0;  // high-side on cycles
  int lo_n = 0;  // low-side on cycles
  // capacitor charges only while the high side conducts
  always @(posedge clk_i) begin
    hi_n <= drv_i.high_side_gate_en ? hi_n + 1 : 0;
    lo_n <= drv_i.low_side_gate_en ? lo_n + 1 : 0;
  end
  assign on_done_o = hi_n >= TON;
  assign half_done_o = hi_n >= TON + TON / 2;
  // current reaches zero 20 cycles into the low phase, gone once released
  assign zc_o = zc_en_i && lo_n >= 20;
endmodule : cotbk_plant

//--- tb/cotbk_channel_props.sv
// checker: gating and timing properties at the channel ports
`timescale 1ns/1ns
module cotbk_channel_props
  import cotbk_pkg::*;
#(
  parameter int DEGLITCH_CYCLES = DEGLITCH_CYC  // power-good filter
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // pins and comparators
  input wire logic EN_PIN_HIGH_I,
  input wire logic EN_PIN_LOW_I,
  input wire logic SUPPLY_OK_I,
  input wire cotbk_cmp_s CMP_I,
  // design outputs
  input wire cotbk_drv_s DRV_O,
  input wire logic [1:0] LIMIT_LEVEL_O,
  input wire logic POWER_GOOD_OUT_O,
  input wire logic POWER_GOOD_OUT_OE_O,
  input wire logic SKIP_MODE_O,
  input wire logic FAULT_LATCHED_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  logic [11:0] off_reg;  // cycles high side off
  logic [11:0] dl_off_reg;  // cycles low side off
  logic [11:0] win_reg;  // cycles output in window
  // saturating idle counter of the high side
  always_ff @(posedge REF_CLK_I) begin
    off_reg <= (RST_I || DRV_O.high_side_gate_en) ? 12'h000 : off_reg + {11'h000, ~&off_reg};
  end
  // saturating idle counter of the low side
  always_ff @(posedge REF_CLK_I) begin
    dl_off_reg <= (RST_I || DRV_O.low_side_gate_en) ? 12'h000 :
      dl_off_reg + {11'h000, ~&dl_off_reg};
  end
  // how long the output has stayed good
  always_ff @(posedge REF_CLK_I) begin
    win_reg <= (RST_I || !(CMP_I.out_in_window && CMP_I.out_above_90)) ? 12'h000 :
      win_reg + {11'h000, ~&win_reg};
  end
  // low side dropped while negative current persists
  sequence s_neg_off;
    CMP_I.neg_ocp [*6] ##0 $fell(DRV_O.low_side_gate_en);
  endsequence
  // low side back on only after the full wait
  sequence s_resense;
    $rose(DRV_O.low_side_gate_en) ##0 (dl_off_reg >= NEG_WAIT_CYC);
  endsequence
  a_neg_retry: assert property (s_neg_off |-> ##[1:700] s_resense)
    else $error("negative current retry wait wrong");
  a_gates_released: assert property (EN_PIN_LOW_I [*6] |-> DRV_O.gates_hiz &&
    !DRV_O.high_side_gate_en && !DRV_O.low_side_gate_en) else $error("gates not released");
  a_limit_low: assert property (DRV_O.limit_src_en |-> DRV_O.low_side_gate_en)
    else $error("limit source on without low side");
  a_ocp_blocks: assert property (CMP_I.pos_ocp [*6] |-> !$rose(DRV_O.high_side_gate_en))
    else $error("turn-on during over-current");
  a_fb_blocks: assert property ((!CMP_I.fb_low) [*6] |-> !$rose(DRV_O.high_side_gate_en))
    else $error("turn-on above regulation");
  a_min_off: assert property ($rose(DRV_O.high_side_gate_en) |-> off_reg >= MIN_OFF_CYC)
    else $error("off-time too short");
  a_pg_filter: assert property ($fell(POWER_GOOD_OUT_OE_O) |-> win_reg >= DEGLITCH_CYCLES)
    else $error("power-good released too early");
  a_pg_open_drain: assert property (POWER_GOOD_OUT_O == 1'b0)
    else $error("power-good drives high");
  a_skip_pin: assert property ((!EN_PIN_HIGH_I) [*6] |-> !SKIP_MODE_O)
    else $error("skip mode without pin high");
endmodule : cotbk_channel_props
bind cotbk_channel cotbk_channel_props #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) u_props (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .EN_PIN_HIGH_I(EN_PIN_HIGH_I),
  .EN_PIN_LOW_I(EN_PIN_LOW_I), .SUPPLY_OK_I(SUPPLY_OK_I), .CMP_I(CMP_I), .DRV_O(DRV_O),
  .LIMIT_LEVEL_O(LIMIT_LEVEL_O), .POWER_GOOD_OUT_O(POWER_GOOD_OUT_O),
  .POWER_GOOD_OUT_OE_O(POWER_GOOD_OUT_OE_O), .SKIP_MODE_O(SKIP_MODE_O),
  .FAULT_LATCHED_O(FAULT_LATCHED_O));

//--- tb/cotbk_channel_tb.sv
// testbench: one buck channel against a switching model
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", n, e, s); end end
module cotbk_channel_tb
  import cotbk_pkg::*;
();
  localparam int DEG = 8;  // shortened filter
  // bench-driven pins and comparator levels
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en_hi = 1'b0;
  logic en_lo = 1'b0;
  logic sup = 1'b1;
  logic fb = 1'b1, pos = 1'b0, neg = 1'b0, win = 1'b1, a90 = 1'b1, u70 = 1'b0, zc_en = 1'b1;
  logic ov = 1'b0;  // output 10 percent high
  // plant and design outputs
  logic on_d, half_d, zc, pg, pg_oe, skip, flt;
  logic [1:0] lim;
  cotbk_cmp_s cmp;
  cotbk_drv_s drv;
  int mismatches = 0, compares = 0, rises = 0;
  logic [31:0] rnd = 32'h36A63D99;
  wire pg_line = pg_oe ? pg : 1'b1;  // external pull-up
  assign cmp = '{on_d, half_d, fb, zc, pos, neg, win, a90, u70, ov};
  always #2 clk = ~clk;
  // count high-side turn-ons
  always @(posedge drv.high_side_gate_en) rises++;
  cotbk_plant #(.TON(8)) u_cotbk_plant (.clk_i(clk), .drv_i(drv), .zc_en_i(zc_en),
    .on_done_o(on_d), .half_done_o(half_d), .zc_o(zc));
  cotbk_channel #(.DEGLITCH_CYCLES(DEG)) u_cotbk_channel (.REF_CLK_I(clk), .RST_I(rst),
    .EN_PIN_HIGH_I(en_hi), .EN_PIN_LOW_I(en_lo), .SUPPLY_OK_I(sup), .CMP_I(cmp),
    .DRV_O(drv), .LIMIT_LEVEL_O(lim), .POWER_GOOD_OUT_O(pg), .POWER_GOOD_OUT_OE_O(pg_oe),
    .SKIP_MODE_O(skip), .FAULT_LATCHED_O(flt));
  // wait falling edges
  task automatic settle(int n);
    repeat (n) @(negedge clk);
  endtask : settle
  // output window and 90 percent level together
  task automatic set_win(logic v);
    win = v;
    a90 = v;
  endtask : set_win
  // xorshift step
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // wait for the next turn-on, bounded
  task automatic next_on;
    int r, k;
    r = rises;
    k = 0;
    while (rises == r && k < 3000) begin
      @(negedge clk);
      k++;
    end
    `CHK("turn_on", 1'b1, drv.high_side_gate_en)
  endtask : next_on
  // length of the current low-side level
  task automatic run_len(logic v, output int len);
    len = 0;
    while (drv.low_side_gate_en === v && len < 1000) begin
      @(negedge clk);
      len++;
    end
  endtask : run_len
  // verdict
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    int n, c, g;
    settle(8);
    `CHK("reset_drv", 6'h08, drv)
    settle(8);
    rst = 1'b0;
    settle(10);
    `CHK("start_low", 1'b1, drv.low_side_gate_en)
    // soft-start in continuous conduction, crossings every cycle
    for (n = 1; n <= SS_TOTAL_CYC; n++) begin
      next_on();
      if (n % SS_PHASE_CYC == 55) begin
        `CHK("limit", 2'(n / SS_PHASE_CYC), lim)
        `CHK("pg_start", 1'b0, pg_line)
      end
      `CHK("no_skip", 1'b0, skip)
    end
    settle(300);
    `CHK("pg_up", 1'b1, pg_line)
    set_win(1'b0);
    settle(DEG / 2);
    set_win(1'b1);
    settle(30);
    `CHK("pg_glitch", 1'b1, pg_line)
    set_win(1'b0);
    settle(40);
    `CHK("pg_drop", 1'b0, pg_line)
    set_win(1'b1);
    settle(40);
    `CHK("pg_back", 1'b1, pg_line)
    // pulse-skip with random crossings
    zc_en = 1'b0;
    next_on();
    next_on();
    en_hi = 1'b1;
    c = 0;
    for (n = 0; n < 60; n++) begin
      next_on();
      c = zc_en ? c + 1 : 0;
      settle(4);
      `CHK("skip", c >= SKIP_ENTRY_CNT, skip)
      `CHK("stretch", c >= SKIP_ENTRY_CNT, drv.on_time_stretch)
      rnd = xs(rnd);
      zc_en = rnd[2:0] != 3'h0;
      settle(50);
      `CHK("low_drop", !(c >= SKIP_ENTRY_CNT && zc_en), drv.low_side_gate_en)
    end
    // over-current, then feedback above regulation
    en_hi = 1'b0;
    zc_en = 1'b0;
    for (n = 0; n < 2; n++) begin
      pos = (n == 0);
      fb = (n == 0);
      settle(8);
      c = rises;
      settle(300);
      `CHK("blocked", c, rises)
      pos = 1'b0;
      fb = 1'b1;
      next_on();
    end
    // negative current retry
    fb = 1'b0;
    settle(300);
    neg = 1'b1;
    run_len(1'b1, g);
    `CHK("neg_off", 1'b1, g <= 5)
    run_len(1'b0, g);
    `CHK("neg_wait", 1'b1, g >= NEG_WAIT_CYC && g <= NEG_WAIT_CYC + 2)
    run_len(1'b1, g);
    `CHK("neg_pulse", 1'b1, g >= NEG_PULSE_CYC && g <= NEG_PULSE_CYC + 1)
    neg = 1'b0;
    fb = 1'b1;
    next_on();
    // undervoltage latch, then clear by the enable pin
    u70 = 1'b1;
    set_win(1'b0);
    settle(40);
    `CHK("uv_latch", 1'b1, flt)
    `CHK("uv_hiz", 3'h1, {drv.high_side_gate_en, drv.low_side_gate_en, drv.gates_hiz})
    u70 = 1'b0;
    set_win(1'b1);
    en_lo = 1'b1;
    settle(10);
    `CHK("off_hiz", 3'h1, {drv.high_side_gate_en, drv.low_side_gate_en, drv.gates_hiz})
    en_lo = 1'b0;
    settle(10);
    `CHK("fault_clear", 1'b0, flt)
    // overvoltage latch holds the low side on, cleared by a supply toggle
    ov = 1'b1;
    settle(40);
    `CHK("ov_latch", 1'b1, flt)
    `CHK("ov_low", 3'h2, {drv.high_side_gate_en, drv.low_side_gate_en, drv.gates_hiz})
    ov = 1'b0;
    sup = 1'b0;
    settle(10);
    sup = 1'b1;
    settle(10);
    `CHK("supply_clear", 1'b0, flt)
    tally_and_finish();
  end
  // watchdog
  initial begin
    repeat (95000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : cotbk_channel_tb
